/* File: src/omc_map.vh */
// Constants shared by the operating-mode control block.
// Assumes it is included by bare name from the design and verification files.
`ifndef OMC_MAP_VH
`define OMC_MAP_VH

// Encoded operating mode.
`define OMC_MODE_REAL 3'h0
`define OMC_MODE_PROT 3'h1
`define OMC_MODE_VM 3'h2
`define OMC_MODE_LONG64 3'h3
`define OMC_MODE_COMPAT 3'h4
`define OMC_MODE_SYSMGMT 3'h5

// Encoded address, operand and stack sizes.
`define OMC_SIZE_16 2'h0
`define OMC_SIZE_32 2'h1
`define OMC_SIZE_64 2'h2

// Privilege levels.
`define OMC_PRIV_0 2'h0
`define OMC_PRIV_3 2'h3

// Reset values.
`define OMC_RST_VM_FLAG 1'h0
`define OMC_RST_SYSMGMT 1'h0

`endif

/* File: src/omc_size_dec.v */
// Default and effective size decoder for the operating-mode control block.
// Assumes mode code and prefix flags come from logic on the same clock.
`include "omc_map.vh"

module omc_size_dec (
  input wire [2:0] mode_i,
  input wire cs_default_big_i,
  input wire opsize_prefix_i,
  input wire adsize_prefix_i,
  input wire rex_w_i,
  output reg [1:0] addr_size_o,
  output reg [1:0] oper_size_o,
  output reg [1:0] stack_size_o
);

  // ----------------------------------------------------------------
  // Size selection
  // ----------------------------------------------------------------
  function [1:0] omc_flip;
    input big;
    input pfx;
    begin
      omc_flip = (big ^ pfx) ? `OMC_SIZE_32 : `OMC_SIZE_16;
    end
  endfunction

  always @* begin
    addr_size_o = `OMC_SIZE_16;
    oper_size_o = `OMC_SIZE_16;
    stack_size_o = `OMC_SIZE_16;
    case (mode_i)
      `OMC_MODE_LONG64: begin
        addr_size_o = adsize_prefix_i ? `OMC_SIZE_32 : `OMC_SIZE_64;
        if (rex_w_i) begin
          oper_size_o = `OMC_SIZE_64;
        end else begin
          oper_size_o = opsize_prefix_i ? `OMC_SIZE_16 : `OMC_SIZE_32;
        end
        stack_size_o = `OMC_SIZE_64;
      end
      `OMC_MODE_COMPAT, `OMC_MODE_PROT: begin
        addr_size_o = omc_flip(cs_default_big_i, adsize_prefix_i);
        oper_size_o = omc_flip(cs_default_big_i, opsize_prefix_i);
        stack_size_o = omc_flip(cs_default_big_i, 1'b0);
      end
      default: begin
        // Real, machine and management modes all start at 16 bits.
        addr_size_o = omc_flip(1'b0, adsize_prefix_i);
        oper_size_o = omc_flip(1'b0, opsize_prefix_i);
        stack_size_o = `OMC_SIZE_16;
      end
    endcase
  end

endmodule

/* File: src/omc_mode_ctrl.v */
// Operating-mode tracking and control for the processor core.
// Assumes control bits, segment attributes and prefixes come from core
// logic on clk_i; the management interrupt arrives on an external pin.
`include "omc_map.vh"

module omc_mode_ctrl (
  input wire clk_i,
  input wire rst_n_i,
  input wire prot_enable_i,
  input wire paging_enable_i,
  input wire long_enable_i,
  input wire cs_long_i,
  input wire cs_default_big_i,
  input wire [1:0] cs_priv_i,
  input wire opsize_prefix_i,
  input wire adsize_prefix_i,
  input wire register_extension_prefix_i,
  input wire rex_w_i,
  input wire vector_extension_prefix_i,
  input wire extended_op_prefix_i,
  input wire flags_load_tss_i,
  input wire interrupt_return_instr_i,
  input wire pop_flags_instr_i,
  input wire flags_vm_value_i,
  input wire sys_mgmt_interrupt_i,
  input wire sys_mgmt_resume_i,
  output reg [2:0] mode_o,
  output reg long_mode_o,
  output reg sub64_o,
  output reg compat_o,
  output reg virtual_machine_flag_o,
  output reg sys_mgmt_mode_o,
  output reg [1:0] addr_size_o,
  output reg [1:0] oper_size_o,
  output reg [1:0] stack_size_o,
  output reg reg_ext_o,
  output reg extra_general_registers_o,
  output reg extra_vector_registers_o,
  output reg upper_half_o,
  output reg uniform_byte_o,
  output reg instruction_pointer_64_o,
  output reg ip_relative_o,
  output reg va_limit_4g_o,
  output reg phys_space_1m_o,
  output reg paging_active_o,
  output reg addr_passthru_o,
  output reg legacy_segmentation_o,
  output reg long_mechanisms_o,
  output reg real_addressing_o,
  output reg seg_limit_4g_o,
  output reg [1:0] cpl_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] ST_REAL = 5'h01;
  localparam [4:0] ST_PROT = 5'h02;
  localparam [4:0] ST_VM = 5'h04;
  localparam [4:0] ST_LONG64 = 5'h08;
  localparam [4:0] ST_COMPAT = 5'h10;

  function omc_is_long;
    input [4:0] st;
    begin
      omc_is_long = st[3] | st[4];
    end
  endfunction

  function [2:0] omc_code;
    input [4:0] st;
    input sys_mgmt_mode;
    begin
      if (sys_mgmt_mode) begin
        omc_code = `OMC_MODE_SYSMGMT;
      end else begin
        case (st)
          ST_PROT: omc_code = `OMC_MODE_PROT;
          ST_VM: omc_code = `OMC_MODE_VM;
          ST_LONG64: omc_code = `OMC_MODE_LONG64;
          ST_COMPAT: omc_code = `OMC_MODE_COMPAT;
          default: omc_code = `OMC_MODE_REAL;
        endcase
      end
    end
  endfunction

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg vm_flag_reg;
  reg vm_flag_next;
  reg smm_reg;
  reg smm_next;
  reg smi_sync1_reg;
  reg smi_sync2_reg;
  reg smi_prev_reg;
  wire long_active;
  wire vm_write;
  wire smi_rise;
  wire [2:0] mode_now;
  wire [1:0] dec_addr;
  wire [1:0] dec_oper;
  wire [1:0] dec_stack;

  // ----------------------------------------------------------------
  // Management interrupt pin synchroniser
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smi_sync1_reg <= 1'b0;
      smi_sync2_reg <= 1'b0;
      smi_prev_reg <= 1'b0;
    end else begin
      smi_sync1_reg <= sys_mgmt_interrupt_i;
      smi_sync2_reg <= smi_sync1_reg;
      smi_prev_reg <= smi_sync2_reg;
    end
  end

  // Recognised on the rising edge, so a held pin does not re-enter.
  assign smi_rise = smi_sync2_reg & ~smi_prev_reg;

  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  // Long mode only activates with paged protected mode underneath; the
  // enabling order itself is left to software.
  assign long_active = long_enable_i & prot_enable_i & paging_enable_i;

  always @* begin
    state_next = ST_REAL;
    case (state_reg)
      ST_REAL, ST_PROT, ST_VM, ST_LONG64, ST_COMPAT: begin
        if (long_active) begin
          // The active code segment picks the submode every cycle.
          state_next = cs_long_i ? ST_LONG64 : ST_COMPAT;
        end else if (prot_enable_i) begin
          state_next = vm_flag_reg ? ST_VM : ST_PROT;
        end else begin
          state_next = ST_REAL;
        end
      end
      default: begin
        state_next = ST_REAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Virtual-machine flag
  // ----------------------------------------------------------------
  // Pop-flags is deliberately absent from the write enable.
  assign vm_write = flags_load_tss_i |
                    (interrupt_return_instr_i &
                     (cs_priv_i == `OMC_PRIV_0));

  always @* begin
    vm_flag_next = vm_flag_reg;
    if (vm_write) begin
      if (long_enable_i & flags_vm_value_i) begin
        // Silently dropped: no fault; the long-enable clear below still zeroes the flag.
        vm_flag_next = vm_flag_reg;
      end else begin
        vm_flag_next = flags_vm_value_i;
      end
    end
    if (long_enable_i) begin
      vm_flag_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Management mode
  // ----------------------------------------------------------------
  always @* begin
    smm_next = smm_reg;
    if (sys_mgmt_resume_i) begin
      smm_next = 1'b0;
    end
    // Entry beats a resume in the same cycle so no interrupt is lost.
    if (smi_rise) begin
      smm_next = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_REAL;
      vm_flag_reg <= `OMC_RST_VM_FLAG;
      smm_reg <= `OMC_RST_SYSMGMT;
    end else begin
      state_reg <= state_next;
      vm_flag_reg <= vm_flag_next;
      smm_reg <= smm_next;
    end
  end

  // ----------------------------------------------------------------
  // Size decode
  // ----------------------------------------------------------------
  assign mode_now = omc_code(state_reg, smm_reg);

  omc_size_dec u_size_dec (
    .mode_i(mode_now),
    .cs_default_big_i(cs_default_big_i),
    .opsize_prefix_i(opsize_prefix_i),
    .adsize_prefix_i(adsize_prefix_i),
    .rex_w_i(rex_w_i),
    .addr_size_o(dec_addr),
    .oper_size_o(dec_oper),
    .stack_size_o(dec_stack)
  );

  // ----------------------------------------------------------------
  // Registered mode outputs
  // ----------------------------------------------------------------
  // Everything is registered one cycle behind the state so downstream
  // decode sees a stable, glitch-free view; the cost is a cycle of lag
  // after a prefix or attribute changes.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o <= `OMC_MODE_REAL;
      long_mode_o <= 1'b0;
      sub64_o <= 1'b0;
      compat_o <= 1'b0;
      virtual_machine_flag_o <= `OMC_RST_VM_FLAG;
      sys_mgmt_mode_o <= `OMC_RST_SYSMGMT;
      addr_size_o <= `OMC_SIZE_16;
      oper_size_o <= `OMC_SIZE_16;
      stack_size_o <= `OMC_SIZE_16;
      reg_ext_o <= 1'b0;
      extra_general_registers_o <= 1'b0;
      extra_vector_registers_o <= 1'b0;
      upper_half_o <= 1'b0;
      uniform_byte_o <= 1'b0;
      instruction_pointer_64_o <= 1'b0;
      ip_relative_o <= 1'b0;
      va_limit_4g_o <= 1'b0;
      phys_space_1m_o <= 1'b1;
      paging_active_o <= 1'b0;
      addr_passthru_o <= 1'b1;
      legacy_segmentation_o <= 1'b0;
      long_mechanisms_o <= 1'b0;
      real_addressing_o <= 1'b1;
      seg_limit_4g_o <= 1'b0;
      cpl_o <= `OMC_PRIV_0;
    end else begin
      mode_o <= mode_now;
      long_mode_o <= omc_is_long(state_reg);
      sub64_o <= (state_reg == ST_LONG64);
      compat_o <= (state_reg == ST_COMPAT);
      virtual_machine_flag_o <= vm_flag_reg;
      sys_mgmt_mode_o <= smm_reg;
      addr_size_o <= dec_addr;
      oper_size_o <= dec_oper;
      stack_size_o <= dec_stack;
      // Extensions need 64-bit submode outside management mode.
      reg_ext_o <= (mode_now == `OMC_MODE_LONG64);
      extra_general_registers_o <= (mode_now == `OMC_MODE_LONG64) &
                                   (register_extension_prefix_i |
                                    vector_extension_prefix_i |
                                    extended_op_prefix_i);
      extra_vector_registers_o <= (mode_now == `OMC_MODE_LONG64) &
                                  (register_extension_prefix_i |
                                   vector_extension_prefix_i |
                                   extended_op_prefix_i);
      upper_half_o <= (mode_now == `OMC_MODE_LONG64);
      uniform_byte_o <= (mode_now == `OMC_MODE_LONG64) &
                        register_extension_prefix_i;
      instruction_pointer_64_o <= (mode_now == `OMC_MODE_LONG64);
      ip_relative_o <= (mode_now == `OMC_MODE_LONG64);
      va_limit_4g_o <= (mode_now == `OMC_MODE_COMPAT) |
                       (mode_now == `OMC_MODE_PROT);
      phys_space_1m_o <= (mode_now == `OMC_MODE_REAL) |
                         (mode_now == `OMC_MODE_VM);
      // Real and management modes never page.
      paging_active_o <= paging_enable_i &
                         ((mode_now == `OMC_MODE_PROT) |
                          (mode_now == `OMC_MODE_VM) |
                          omc_is_long(state_reg)) &
                         ~smm_reg;
      addr_passthru_o <= ~paging_enable_i |
                         (mode_now == `OMC_MODE_REAL) |
                         (mode_now == `OMC_MODE_SYSMGMT);
      legacy_segmentation_o <= (mode_now == `OMC_MODE_COMPAT) |
                               (mode_now == `OMC_MODE_PROT);
      long_mechanisms_o <= omc_is_long(state_reg) & ~smm_reg;
      real_addressing_o <= (mode_now == `OMC_MODE_REAL) |
                           (mode_now == `OMC_MODE_VM) |
                           (mode_now == `OMC_MODE_SYSMGMT);
      seg_limit_4g_o <= (mode_now == `OMC_MODE_SYSMGMT);
      case (mode_now)
        `OMC_MODE_REAL: cpl_o <= `OMC_PRIV_0;
        `OMC_MODE_SYSMGMT: cpl_o <= `OMC_PRIV_0;
        `OMC_MODE_VM: cpl_o <= `OMC_PRIV_3;
        default: cpl_o <= cs_priv_i;
      endcase
    end
  end

endmodule

/* File: verif/omc_mode_ctrl_monitor.sv */
// Concurrent checks on the ports of the operating-mode control block.
// Assumes one core clock and the active-low asynchronous reset.
`include "omc_map.vh"

module omc_mode_ctrl_monitor (
  input logic clk_i,
  input logic rst_n_i,
  input logic prot_enable_i,
  input logic paging_enable_i,
  input logic long_enable_i,
  input logic opsize_prefix_i,
  input logic adsize_prefix_i,
  input logic rex_w_i,
  input logic flags_load_tss_i,
  input logic interrupt_return_instr_i,
  input logic sys_mgmt_interrupt_i,
  input logic [2:0] mode_o,
  input logic long_mode_o,
  input logic sub64_o,
  input logic virtual_machine_flag_o,
  input logic sys_mgmt_mode_o,
  input logic [1:0] addr_size_o,
  input logic [1:0] oper_size_o,
  input logic reg_ext_o,
  input logic phys_space_1m_o,
  input logic [1:0] cpl_o
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_reset_real: assert property (
    $rose(rst_n_i) |-> mode_o == `OMC_MODE_REAL) else $error("not real");
  chk_long_legacy: assert property (
    long_mode_o |-> mode_o != `OMC_MODE_REAL && mode_o != `OMC_MODE_VM)
    else $error("legacy mode under long");
  chk_long_needs: assert property (
    long_mode_o |-> $past(prot_enable_i, 2) && $past(paging_enable_i, 2)
    && $past(long_enable_i, 2)) else $error("long without enables");
  chk_ext_only64: assert property (
    reg_ext_o |-> mode_o == `OMC_MODE_LONG64) else $error("ext outside 64");
  chk_sub64_flags: assert property (
    mode_o == `OMC_MODE_LONG64 |-> sub64_o && long_mode_o && reg_ext_o)
    else $error("64-bit flags wrong");
  chk_sizes_64: assert property (
    mode_o == `OMC_MODE_LONG64 && !$past(opsize_prefix_i) &&
    !$past(adsize_prefix_i) && !$past(rex_w_i) |->
    addr_size_o == `OMC_SIZE_64 && oper_size_o == `OMC_SIZE_32)
    else $error("64-bit default sizes wrong");
  chk_vm_source: assert property (
    $changed(virtual_machine_flag_o) |-> $past(flags_load_tss_i, 2) ||
    $past(interrupt_return_instr_i, 2) || $past(long_enable_i, 2))
    else $error("vm flag changed without cause");
  chk_vm_ignored: assert property (
    long_enable_i [*3] |-> !virtual_machine_flag_o) else $error("vm set");
  chk_mgmt_entry: assert property (
    $rose(sys_mgmt_interrupt_i) |-> ##[1:5] sys_mgmt_mode_o)
    else $error("mgmt mode not entered");
  chk_mgmt_code: assert property (
    (mode_o == `OMC_MODE_SYSMGMT) == sys_mgmt_mode_o)
    else $error("mgmt output disagrees with mode");
  chk_level_zero: assert property (
    mode_o == `OMC_MODE_REAL || mode_o == `OMC_MODE_SYSMGMT |->
    cpl_o == `OMC_PRIV_0) else $error("level not zero");
  chk_vm_level: assert property (
    mode_o == `OMC_MODE_VM |-> cpl_o == `OMC_PRIV_3 && phys_space_1m_o)
    else $error("vm level or space wrong");
endmodule

bind omc_mode_ctrl omc_mode_ctrl_monitor omc_mode_ctrl_monitor_inst (.*);

/* File: verif/omc_mode_ctrl_test.sv */
// Self-checking bench for the operating-mode control block.
// Assumes the block's ports are driven directly on the core clock.
`include "omc_map.vh"

module omc_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, prot_enable_i, paging_enable_i, long_enable_i;
  logic cs_long_i, cs_default_big_i, opsize_prefix_i, adsize_prefix_i;
  logic register_extension_prefix_i, rex_w_i, vector_extension_prefix_i;
  logic extended_op_prefix_i, flags_load_tss_i, interrupt_return_instr_i;
  logic pop_flags_instr_i, flags_vm_value_i, sys_mgmt_interrupt_i;
  logic sys_mgmt_resume_i, long_mode_o, sub64_o, compat_o, reg_ext_o;
  logic virtual_machine_flag_o, sys_mgmt_mode_o, extra_general_registers_o;
  logic extra_vector_registers_o, upper_half_o, uniform_byte_o, ip_relative_o;
  logic instruction_pointer_64_o, va_limit_4g_o, phys_space_1m_o;
  logic paging_active_o, addr_passthru_o, legacy_segmentation_o;
  logic long_mechanisms_o, real_addressing_o, seg_limit_4g_o;
  logic [1:0] cs_priv_i, addr_size_o, oper_size_o, stack_size_o, cpl_o;
  logic [2:0] mode_o;
  int checks = 0;
  int n_mismatch = 0;
  int cycles = 0;

  omc_mode_ctrl omc_mode_ctrl_inst (.*);

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic note(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic chk_mode(input logic [2:0] e);
    note(mode_o === e, "mode code");
  endtask
  task automatic chk_flag(input logic g, input logic e, input string m);
    note(g === e, m);
  endtask
  task automatic chk_size(input logic [1:0] g, e, input string m);
    note(g === e, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic final_report();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole sequence takes about 85 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'h0;
    cs_priv_i = 2'h2;
    {prot_enable_i, paging_enable_i, long_enable_i, cs_long_i} = '0;
    {cs_default_big_i, opsize_prefix_i, adsize_prefix_i, rex_w_i} = '0;
    {register_extension_prefix_i, vector_extension_prefix_i} = '0;
    {extended_op_prefix_i, flags_load_tss_i, interrupt_return_instr_i} = '0;
    {pop_flags_instr_i, flags_vm_value_i, sys_mgmt_interrupt_i} = '0;
    sys_mgmt_resume_i = 1'h0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    tick(2);
    chk_mode(`OMC_MODE_REAL);
    chk_flag(phys_space_1m_o, 1'h1, "real space");
    chk_size(cpl_o, `OMC_PRIV_0, "real level");
    chk_size(oper_size_o, `OMC_SIZE_16, "real operand");
    @(posedge clk_i) opsize_prefix_i <= 1'h1;
    tick(3);
    chk_size(oper_size_o, `OMC_SIZE_32, "real prefix");
    @(posedge clk_i) begin
      opsize_prefix_i <= 1'h0;
      prot_enable_i <= 1'h1;
    end
    tick(3);
    chk_mode(`OMC_MODE_PROT);
    chk_flag(addr_passthru_o, 1'h1, "unpaged passthru");
    chk_size(cpl_o, 2'h2, "prot level");
    chk_size(oper_size_o, `OMC_SIZE_16, "prot 16");
    @(posedge clk_i) cs_default_big_i <= 1'h1;
    tick(3);
    chk_size(oper_size_o, `OMC_SIZE_32, "prot 32");
    // Neither pop-flags nor a return at level two may set the flag.
    @(posedge clk_i) begin
      flags_vm_value_i <= 1'h1;
      pop_flags_instr_i <= 1'h1;
    end
    @(posedge clk_i) pop_flags_instr_i <= 1'h0;
    interrupt_return_instr_i <= 1'h1;
    @(posedge clk_i) interrupt_return_instr_i <= 1'h0;
    tick(3);
    chk_flag(virtual_machine_flag_o, 1'h0, "vm unprivileged");
    @(posedge clk_i) begin
      cs_priv_i <= 2'h0;
      interrupt_return_instr_i <= 1'h1;
    end
    @(posedge clk_i) interrupt_return_instr_i <= 1'h0;
    tick(3);
    chk_mode(`OMC_MODE_VM);
    chk_size(cpl_o, `OMC_PRIV_3, "vm level");
    chk_flag(real_addressing_o, 1'h1, "vm addressing");
    @(posedge clk_i) begin
      flags_vm_value_i <= 1'h0;
      flags_load_tss_i <= 1'h1;
    end
    @(posedge clk_i) flags_load_tss_i <= 1'h0;
    tick(3);
    chk_mode(`OMC_MODE_PROT);
    // Paged protected mode is in place an edge before long mode is enabled.
    @(posedge clk_i) paging_enable_i <= 1'h1;
    @(posedge clk_i) begin
      long_enable_i <= 1'h1;
      cs_long_i <= 1'h1;
      cs_default_big_i <= 1'h0;
    end
    tick(3);
    chk_mode(`OMC_MODE_LONG64);
    chk_size(addr_size_o, `OMC_SIZE_64, "64 address");
    chk_size(oper_size_o, `OMC_SIZE_32, "64 operand");
    chk_flag(upper_half_o, 1'h1, "upper half");
    chk_flag(instruction_pointer_64_o & ip_relative_o, 1'h1, "ip");
    @(posedge clk_i) begin
      register_extension_prefix_i <= 1'h1;
      rex_w_i <= 1'h1;
      adsize_prefix_i <= 1'h1;
    end
    tick(3);
    chk_size(oper_size_o, `OMC_SIZE_64, "rex operand");
    chk_size(addr_size_o, `OMC_SIZE_32, "address prefix");
    chk_flag(extra_general_registers_o, 1'h1, "extra general");
    chk_flag(uniform_byte_o, 1'h1, "uniform byte");
    @(posedge clk_i) begin
      {register_extension_prefix_i, rex_w_i, adsize_prefix_i} <= '0;
      vector_extension_prefix_i <= 1'h1;
      flags_vm_value_i <= 1'h1;
      flags_load_tss_i <= 1'h1;
    end
    @(posedge clk_i) flags_load_tss_i <= 1'h0;
    tick(3);
    chk_flag(extra_vector_registers_o, 1'h1, "extra vector");
    chk_flag(uniform_byte_o, 1'h0, "byte needs rex");
    chk_flag(virtual_machine_flag_o, 1'h0, "vm under long");
    chk_mode(`OMC_MODE_LONG64);
    @(posedge clk_i) begin
      vector_extension_prefix_i <= 1'h0;
      extended_op_prefix_i <= 1'h1;
    end
    tick(3);
    chk_flag(extra_general_registers_o, 1'h1, "extended op");
    @(posedge clk_i) begin
      extended_op_prefix_i <= 1'h0;
      cs_long_i <= 1'h0;
      cs_default_big_i <= 1'h1;
    end
    tick(3);
    chk_mode(`OMC_MODE_COMPAT);
    chk_flag(long_mode_o & compat_o & ~sub64_o, 1'h1, "compat");
    chk_flag(reg_ext_o, 1'h0, "no ext");
    chk_flag(va_limit_4g_o, 1'h1, "4g limit");
    chk_flag(legacy_segmentation_o & long_mechanisms_o, 1'h1, "seg");
    chk_flag(paging_active_o, 1'h1, "compat paging");
    @(posedge clk_i) begin
      opsize_prefix_i <= 1'h1;
      adsize_prefix_i <= 1'h1;
    end
    tick(3);
    chk_size(oper_size_o, `OMC_SIZE_16, "compat operand");
    chk_size(addr_size_o, `OMC_SIZE_16, "compat address");
    @(posedge clk_i) begin
      {opsize_prefix_i, adsize_prefix_i} <= '0;
      sys_mgmt_interrupt_i <= 1'h1;
    end
    repeat (2) @(posedge clk_i);
    sys_mgmt_interrupt_i <= 1'h0;
    tick(4);
    chk_mode(`OMC_MODE_SYSMGMT);
    chk_flag(sys_mgmt_mode_o, 1'h1, "mgmt pin");
    chk_flag(seg_limit_4g_o & real_addressing_o, 1'h1, "mgmt addr");
    chk_size(stack_size_o, `OMC_SIZE_16, "mgmt stack");
    chk_size(addr_size_o, `OMC_SIZE_16, "mgmt address");
    chk_flag(paging_active_o, 1'h0, "mgmt unpaged");
    @(posedge clk_i) opsize_prefix_i <= 1'h1;
    tick(3);
    chk_size(oper_size_o, `OMC_SIZE_32, "mgmt override");
    @(posedge clk_i) sys_mgmt_resume_i <= 1'h1;
    @(posedge clk_i) sys_mgmt_resume_i <= 1'h0;
    tick(3);
    chk_flag(sys_mgmt_mode_o, 1'h0, "mgmt left");
    chk_mode(`OMC_MODE_COMPAT);
    // A reset in mid-run must drop the block back to real mode at once.
    @(posedge clk_i) rst_n_i <= 1'h0;
    tick(1);
    chk_mode(`OMC_MODE_REAL);
    // After the second release the first edge still shows real mode, the
    // next one the submode picked by the live enables and code segment.
    @(posedge clk_i) rst_n_i <= 1'h1;
    tick(1);
    chk_mode(`OMC_MODE_REAL);
    tick(1);
    chk_mode(`OMC_MODE_COMPAT);
    final_report();
  end
endmodule
